// ---- hdl/smr_pkg.sv ----
// package for the setpoint relay alarm and menu block
package smr_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_S;
	localparam int unsigned TIMEOUT_S = 15;
	localparam logic [3:0] TIMEOUT_LAST = 4'(TIMEOUT_S - 1);
	localparam logic signed [14:0] THR_MIN = -15'sd1999;
	localparam logic signed [14:0] THR_MAX = 15'sd9999;
	localparam logic signed [14:0] DLY_MIN = 15'sd0;
	localparam logic signed [14:0] DLY_MAX = 15'sd9999;
	localparam logic signed [14:0] DB_MIN = 15'sd0;
	localparam logic signed [14:0] DB_MAX = 15'sd9999;
	localparam logic [14:0] THR_RST = 15'h0000;
	localparam logic [14:0] DLY_RST = 15'h0000;
	localparam logic [14:0] DB_RST = 15'h0000;
	localparam logic [2:0] POL_RST = 3'h7;
	localparam logic [4:0] OFS_READING = 5'h00;
	localparam logic [4:0] OFS_STATUS = 5'h04;
	localparam logic [4:0] OFS_THR1 = 5'h08;
	localparam logic [4:0] OFS_THR2 = 5'h0c;
	localparam logic [4:0] OFS_THR3 = 5'h10;
	localparam logic [4:0] OFS_SETUP = 5'h14;

	typedef enum logic [3:0] {
		M_OPER, M_THR1, M_MK1, M_BK1, M_DB1, M_THR2, M_MK2, M_BK2, M_DB2, M_THR3, M_DB3, M_POL
	} smr_menu_type;

	typedef struct packed {
		logic prog;
		logic up;
		logic down;
	} smr_btn_type;

	typedef struct packed {
		logic [4:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
	} smr_avs_req_type;

	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} smr_avs_rsp_type;

	typedef struct packed {
		logic show_label;
		smr_menu_type item;
		logic [14:0] value;
	} smr_disp_type;

	typedef struct packed {
		logic [1:0][6:0] pin_sync;
		smr_btn_type btn_prev;
		logic [25:0] sec_cnt;
		logic sec_tick;
		logic blink;
		logic [3:0] idle;
		smr_menu_type menu;
		logic [14:0] edit;
		logic [2:0][14:0] thr;
		logic [1:0][14:0] mk;
		logic [1:0][14:0] bk;
		logic [2:0][14:0] db;
		logic [2:0] pol;
		logic [2:0] alarm;
		logic [2:0][13:0] cnt;
		logic [14:0] reading;
		logic ack;
		logic [31:0] rdata;
		smr_disp_type disp;
	} smr_state_type;
endpackage

// ---- hdl/smr_setpoint_menu.sv ----
// setpoint relay alarms with three-button setting menu and avalon register slave
`timescale 1ns/1ps

// Overview of operation
// - program plus up from live display enters menu at first threshold
// - up and down raise or lower the value being edited
// - program after first threshold moves to its make delay item
// - make delay accepted in whole seconds from 0 to 9999
// - relay energizes only after alarm held for whole make delay; loss restarts
// - program after make delay moves to break delay item
// - program after break delay moves to deadband item of same threshold
// - second threshold has same four items in same order
// - program after second deadband shows third threshold
// - third threshold has no delays; confirm goes to its deadband
// - program after third deadband moves to relay polarity item
// - high polarity energizes above threshold, low energizes below
// - polarity item shows one letter per threshold, first to third
// - with the third relay missing the polarity item cycles the four combinations
// - program on polarity item leaves menu for live reading
// - items of relays not fitted are left out of the menu
// - thresholds without relay still indicate alarm but drive no output
// - lockout jumper blocks entry to programming
// - fifteen seconds without a button press abandons the menu
// - on timeout the unconfirmed edit is dropped, confirmed values kept
module smr_setpoint_menu #(
	parameter int unsigned SEC_CYCLES = smr_pkg::SEC_CYCLES
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire smr_pkg::smr_btn_type btn_pin,
	input wire logic lockout_pin,
	input wire logic [2:0] relay_fitted_pin,
	input wire smr_pkg::smr_avs_req_type avs_req,
	output smr_pkg::smr_avs_rsp_type avs_rsp,
	output logic [2:0] relay_out,
	output logic [2:0] alarm_led,
	output logic [2:0] alarm_ind,
	output smr_pkg::smr_disp_type disp
);
	import smr_pkg::*;

	if (SEC_CYCLES < 2 || SEC_CYCLES > 2 ** 26) begin : g_bad_sec
		$error("SEC_CYCLES out of range for the second divider");
	end

	smr_state_type s_q;
	smr_state_type s_d;
	smr_btn_type btn;
	smr_btn_type press;
	logic lock;
	logic [2:0] fit;
	logic timeout;
	logic entry;
	logic [2:0] trip;
	logic [2:0] clear;
	logic [2:0][14:0] mk_lim;
	logic [2:0][14:0] bk_lim;

	function automatic logic item_shown(smr_menu_type m, logic [2:0] f);
		case (m)
			M_THR1, M_MK1, M_BK1, M_DB1: item_shown = f[0];
			M_THR2, M_MK2, M_BK2, M_DB2: item_shown = f[1];
			M_THR3, M_DB3: item_shown = f[2];
			default: item_shown = 1'b1;
		endcase
	endfunction

	// walks the fixed item order, skipping items of missing relays
	function automatic smr_menu_type menu_after(smr_menu_type m, logic [2:0] f);
		smr_menu_type n;
		n = m;
		for (int k = 0; k < 12; k++) begin
			n = (n == M_POL) ? M_OPER : smr_menu_type'(4'(n + 4'h1));
			if (item_shown(n, f)) begin
				break;
			end
		end
		return n;
	endfunction

	function automatic logic [14:0] stored_val(smr_menu_type m, smr_state_type s);
		case (m)
			M_THR1: stored_val = s.thr[0];
			M_MK1: stored_val = s.mk[0];
			M_BK1: stored_val = s.bk[0];
			M_DB1: stored_val = s.db[0];
			M_THR2: stored_val = s.thr[1];
			M_MK2: stored_val = s.mk[1];
			M_BK2: stored_val = s.bk[1];
			M_DB2: stored_val = s.db[1];
			M_THR3: stored_val = s.thr[2];
			M_DB3: stored_val = s.db[2];
			M_POL: stored_val = {12'h000, s.pol};
			default: stored_val = s.reading;
		endcase
	endfunction

	function automatic logic signed [14:0] lim_lo(smr_menu_type m);
		case (m)
			M_THR1, M_THR2, M_THR3: lim_lo = THR_MIN;
			M_MK1, M_BK1, M_MK2, M_BK2: lim_lo = DLY_MIN;
			default: lim_lo = DB_MIN;
		endcase
	endfunction

	function automatic logic signed [14:0] lim_hi(smr_menu_type m);
		case (m)
			M_THR1, M_THR2, M_THR3: lim_hi = THR_MAX;
			M_MK1, M_BK1, M_MK2, M_BK2: lim_hi = DLY_MAX;
			default: lim_hi = DB_MAX;
		endcase
	endfunction

	// pins are read only after the second stage
	assign btn = s_q.pin_sync[1][6:4];
	assign lock = s_q.pin_sync[1][3];
	assign press = btn & ~s_q.btn_prev;
	assign timeout = s_q.sec_tick && s_q.idle == TIMEOUT_LAST && s_q.menu != M_OPER;
	assign entry = s_q.menu == M_OPER && btn.prog && btn.up && (press.prog || press.up) && !lock;
	assign mk_lim = {DLY_RST, s_q.mk[1], s_q.mk[0]};
	assign bk_lim = {DLY_RST, s_q.bk[1], s_q.bk[0]};

	always_comb begin
		logic signed [16:0] r;
		logic signed [16:0] t;
		logic signed [16:0] d;
		r = 17'($signed(s_q.reading));
		t = 17'sd0;
		d = 17'sd0;
		for (int i = 0; i < 3; i++) begin
			t = 17'($signed(s_q.thr[i]));
			d = 17'($signed(s_q.db[i]));
			trip[i] = s_q.pol[i] ? (r > t) : (r < t);
			clear[i] = s_q.pol[i] ? (r < t - d) : (r > t + d);
		end
	end

	assign fit = s_q.pin_sync[1][2:0];

	always_comb begin
		logic signed [14:0] e;
		s_d = s_q;
		e = $signed(s_q.edit);
		s_d.pin_sync[0] = {btn_pin, lockout_pin, relay_fitted_pin};
		s_d.pin_sync[1] = s_q.pin_sync[0];
		s_d.btn_prev = btn;
		s_d.sec_tick = 1'b0;
		if (s_q.sec_cnt == 26'(SEC_CYCLES - 1)) begin
			s_d.sec_cnt = 26'h0;
			s_d.sec_tick = 1'b1;
			s_d.blink = ~s_q.blink;
		end else begin
			s_d.sec_cnt = s_q.sec_cnt + 26'h1;
		end
		if (press != 3'b000 || s_q.menu == M_OPER) begin
			s_d.idle = 4'h0;
		end else if (s_q.sec_tick) begin
			s_d.idle = s_q.idle + 4'h1;
		end
		case (s_q.menu)
			M_OPER: begin
				if (entry) begin
					s_d.menu = menu_after(M_OPER, fit);
					s_d.edit = stored_val(s_d.menu, s_q);
					s_d.blink = 1'b1;
				end
			end
			default: begin
				if (timeout) begin
					s_d.menu = M_OPER;
				end else if (press.prog) begin
					case (s_q.menu)
						M_THR1: s_d.thr[0] = s_q.edit;
						M_MK1: s_d.mk[0] = s_q.edit;
						M_BK1: s_d.bk[0] = s_q.edit;
						M_DB1: s_d.db[0] = s_q.edit;
						M_THR2: s_d.thr[1] = s_q.edit;
						M_MK2: s_d.mk[1] = s_q.edit;
						M_BK2: s_d.bk[1] = s_q.edit;
						M_DB2: s_d.db[1] = s_q.edit;
						M_THR3: s_d.thr[2] = s_q.edit;
						M_DB3: s_d.db[2] = s_q.edit;
						default: s_d.pol = s_q.edit[2:0];
					endcase
					s_d.menu = menu_after(s_q.menu, fit);
					s_d.edit = stored_val(s_d.menu, s_q);
					s_d.blink = 1'b1;
				end else if (s_q.menu == M_POL && (press.up || press.down)) begin
					// missing third relay keeps its letter and cycles the two left ones
					if (fit[2]) begin
						s_d.edit[2:0] = press.up ? s_q.edit[2:0] + 3'h1 : s_q.edit[2:0] - 3'h1;
					end else begin
						s_d.edit[1:0] = press.up ? s_q.edit[1:0] + 2'h1 : s_q.edit[1:0] - 2'h1;
					end
				end else if (press.up && e < lim_hi(s_q.menu)) begin
					s_d.edit = s_q.edit + 15'h0001;
				end else if (press.down && e > lim_lo(s_q.menu)) begin
					s_d.edit = s_q.edit - 15'h0001;
				end
			end
		endcase
		// delay counters count whole seconds while the condition holds
		for (int i = 0; i < 3; i++) begin
			if (!s_q.alarm[i]) begin
				if (!trip[i]) begin
					s_d.cnt[i] = 14'h0;
				end else if ({1'b0, s_q.cnt[i]} >= mk_lim[i]) begin
					s_d.alarm[i] = 1'b1;
					s_d.cnt[i] = 14'h0;
				end else if (s_q.sec_tick) begin
					s_d.cnt[i] = s_q.cnt[i] + 14'h1;
				end
			end else begin
				if (!clear[i]) begin
					s_d.cnt[i] = 14'h0;
				end else if ({1'b0, s_q.cnt[i]} >= bk_lim[i]) begin
					s_d.alarm[i] = 1'b0;
					s_d.cnt[i] = 14'h0;
				end else if (s_q.sec_tick) begin
					s_d.cnt[i] = s_q.cnt[i] + 14'h1;
				end
			end
		end
		// one wait state: read data is captured on the edge that drops waitrequest
		s_d.ack = (avs_req.read || avs_req.write) && !s_q.ack;
		if (avs_req.read && !s_q.ack) begin
			if (avs_req.address == OFS_READING) begin
				s_d.rdata = {{17{s_q.reading[14]}}, s_q.reading};
			end else if (avs_req.address == OFS_STATUS) begin
				s_d.rdata = {17'h0, s_q.menu, lock, fit, s_q.alarm, s_q.alarm & fit, 1'b0};
			end else if (avs_req.address == OFS_THR1) begin
				s_d.rdata = {{17{s_q.thr[0][14]}}, s_q.thr[0]};
			end else if (avs_req.address == OFS_THR2) begin
				s_d.rdata = {{17{s_q.thr[1][14]}}, s_q.thr[1]};
			end else if (avs_req.address == OFS_THR3) begin
				s_d.rdata = {{17{s_q.thr[2][14]}}, s_q.thr[2]};
			end else if (avs_req.address == OFS_SETUP) begin
				s_d.rdata = {29'h0, s_q.pol};
			end else begin
				s_d.rdata = 32'h0;
			end
		end
		if (avs_req.write && s_q.ack && avs_req.address == OFS_READING) begin
			s_d.reading = avs_req.writedata[14:0];
		end
		s_d.disp.show_label = s_d.blink;
		s_d.disp.item = s_d.menu;
		s_d.disp.value = (s_d.menu == M_OPER) ? s_d.reading : s_d.edit;
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.menu <= M_OPER;
			s_q.thr <= {3{THR_RST}};
			s_q.mk <= {2{DLY_RST}};
			s_q.bk <= {2{DLY_RST}};
			s_q.db <= {3{DB_RST}};
			s_q.pol <= POL_RST;
			s_q.disp.item <= M_OPER;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_rsp.readdata = s_q.rdata;
	assign avs_rsp.waitrequest = (avs_req.read || avs_req.write) && !s_q.ack;
	assign relay_out = s_q.alarm & fit;
	assign alarm_led = s_q.alarm & fit;
	assign alarm_ind = s_q.alarm;
	assign disp = s_q.disp;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence prog_step(smr_menu_type m);
		s_q.menu == m && press.prog && !timeout && item_shown(m, fit);
	endsequence

	a_lock_blocks_entry:
	assert property (s_q.menu == M_OPER && lock |=> s_q.menu == M_OPER)
	else $error("menu entered while locked out");

	a_entry_first_item:
	assert property (entry && fit[0] |=> s_q.menu == M_THR1 && s_q.edit == $past(s_q.thr[0]))
	else $error("entry did not show first threshold");

	a_make_after_thr:
	assert property (prog_step(M_THR1) |=> s_q.menu == M_MK1 && s_q.thr[0] == $past(s_q.edit))
	else $error("first threshold not stored or wrong next item");

	a_third_no_delays:
	assert property (prog_step(M_THR3) |=> s_q.menu == M_DB3)
	else $error("third threshold not followed by its deadband");

	a_polarity_exit:
	assert property (prog_step(M_POL) |=> s_q.menu == M_OPER && disp.item == M_OPER)
	else $error("polarity confirm did not return to live display");

	a_timeout_discard:
	assert property (timeout |=> s_q.menu == M_OPER && $stable(s_q.thr) && $stable(s_q.db) && $stable(s_q.pol))
	else $error("timeout did not drop the edit");

	a_make_restart:
	assert property (!s_q.alarm[0] && !trip[0] |=> !s_q.alarm[0] && s_q.cnt[0] == 14'h0)
	else $error("make delay not restarted on alarm loss");

	a_third_make_none:
	assert property (!s_q.alarm[2] && trip[2] |=> s_q.alarm[2])
	else $error("third threshold should energize without delay");

	a_relay_only_fitted:
	assert property ((relay_out & ~fit) == 3'h0 && alarm_led == relay_out)
	else $error("output driven for relay not fitted");

	a_two_relay_pol:
	assert property (s_q.menu == M_POL && !fit[2] && (press.up || press.down) && !press.prog && !timeout
		|=> s_q.edit[2] == $past(s_q.edit[2]))
	else $error("polarity of missing relay changed");

	a_bus_one_wait:
	assert property ((avs_req.read || avs_req.write) && !s_q.ack |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest)
	else $error("bus answer not after one wait state");

	a_edit_step_up:
	assert property (s_q.menu == M_THR1 && press == 3'b010 && !timeout && $signed(s_q.edit) < THR_MAX
		|=> s_q.edit == $past(s_q.edit) + 15'h0001)
	else $error("up press did not raise the edited value");

	a_delay_floor:
	assert property (s_q.menu inside {M_MK1, M_BK1, M_MK2, M_BK2} && press == 3'b001 && !timeout
		&& s_q.edit == 15'h0000 |=> s_q.edit == 15'h0000)
	else $error("delay went below zero seconds");

	a_break_after_make:
	assert property (prog_step(M_MK1) |=> s_q.menu == M_BK1 && s_q.mk[0] == $past(s_q.edit))
	else $error("make delay not stored or wrong next item");

	a_band_after_break:
	assert property (prog_step(M_BK1) |=> s_q.menu == M_DB1 && s_q.bk[0] == $past(s_q.edit))
	else $error("break delay not stored or wrong next item");

	a_second_same_order:
	assert property (prog_step(M_THR2) |=> s_q.menu == M_MK2 && s_q.thr[1] == $past(s_q.edit))
	else $error("second threshold not stored or wrong next item");

	a_third_after_second:
	assert property (prog_step(M_DB2) ##0 fit[2] |=> s_q.menu == M_THR3)
	else $error("second deadband not followed by third threshold");

	a_polarity_after_band:
	assert property (prog_step(M_DB3) |=> s_q.menu == M_POL && s_q.db[2] == $past(s_q.edit))
	else $error("third deadband not followed by polarity item");

	a_skip_missing_second:
	assert property (prog_step(M_DB1) ##0 !fit[1] ##0 fit[2] |=> s_q.menu == M_THR3)
	else $error("items of missing second relay not skipped");

	a_no_early_exit:
	assert property (s_q.menu != M_OPER && press == 3'b000 && s_q.sec_tick && s_q.idle < TIMEOUT_LAST
		|=> s_q.menu == $past(s_q.menu))
	else $error("menu left before the idle timeout");

	a_hold_in_band:
	assert property (s_q.alarm[0] && !clear[0] |=> s_q.alarm[0])
	else $error("relay released inside the deadband");

	a_high_energizes:
	assert property (s_q.pol[2] && $signed(s_q.reading) > $signed(s_q.thr[2]) && !s_q.alarm[2]
		|=> s_q.alarm[2])
	else $error("high polarity did not energize above threshold");

	a_two_relay_cycle:
	assert property (s_q.menu == M_POL && !fit[2] && press == 3'b010 && !timeout
		|=> s_q.edit[1:0] == $past(s_q.edit[1:0]) + 2'h1)
	else $error("two relay polarity did not step");
endmodule

// ---- dv/smr_panel_model.sv ----
// front panel button model for the setpoint relay menu bench
`timescale 1ns/1ps
module smr_panel_model (
	input wire logic core_clk,
	output smr_pkg::smr_btn_type btn
);
	import smr_pkg::*;
	initial begin
		btn = '0;
	end
	// held well past the two-stage synchroniser, then a gap, so each press is seen exactly once
	task automatic press(input smr_btn_type b);
		btn <= b;
		repeat (4) @(posedge core_clk);
		btn <= '0;
		repeat (6) @(posedge core_clk);
	endtask
endmodule

// ---- dv/smr_setpoint_menu_tb_top.sv ----
// self-checking bench for the setpoint relay menu block
`timescale 1ns/1ps
module smr_setpoint_menu_tb_top;
	import smr_pkg::*;
	typedef struct packed {
		smr_btn_type b;
		smr_menu_type it;
		logic [14:0] v;
	} smr_row_type;
	logic core_clk;
	logic rstn;
	logic lockout_pin;
	logic [2:0] relay_fitted_pin;
	smr_btn_type btn_pin;
	smr_avs_req_type avs_req;
	smr_avs_rsp_type avs_rsp;
	logic [2:0] relay_out;
	logic [2:0] alarm_led;
	logic [2:0] alarm_ind;
	smr_disp_type disp;
	smr_row_type rows [20];
	logic [31:0] rd;
	int failures;
	int samples_checked;
	int n;
	logic lbl;

	// short second so make delays and the idle timeout fit a brief run
	smr_setpoint_menu #(.SEC_CYCLES(20)) smr_setpoint_menu_inst (
		.core_clk(core_clk),
		.rstn(rstn),
		.btn_pin(btn_pin),
		.lockout_pin(lockout_pin),
		.relay_fitted_pin(relay_fitted_pin),
		.avs_req(avs_req),
		.avs_rsp(avs_rsp),
		.relay_out(relay_out),
		.alarm_led(alarm_led),
		.alarm_ind(alarm_ind),
		.disp(disp)
	);
	smr_panel_model smr_panel_model_inst (
		.core_clk(core_clk),
		.btn(btn_pin)
	);

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask

	// request held until the edge where waitrequest is low, then released with one idle cycle
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_req <= '{address: a, read: !wr, write: wr, writedata: d};
		do begin
			@(posedge core_clk);
			k++;
		end while (avs_rsp.waitrequest !== 1'b0 && k < 50);
		rd = avs_rsp.readdata;
		avs_req <= '0;
		@(posedge core_clk);
		if (k >= 50) begin
			failures++;
		end
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	task automatic pr(input smr_btn_type b);
		smr_panel_model_inst.press(b);
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		cyc(20000);
		failures++;
		end_of_test();
	end

	initial begin
		rstn = 1'b0;
		lockout_pin = 1'b0;
		relay_fitted_pin = 3'b111;
		avs_req = '0;
		failures = 0;
		samples_checked = 0;
		rows = '{'{3'b110, M_THR1, 15'h0}, '{3'b010, M_THR1, 15'h1}, '{3'b010, M_THR1, 15'h2}, '{3'b001, M_THR1, 15'h1},
			'{3'b100, M_MK1, 15'h0}, '{3'b010, M_MK1, 15'h1}, '{3'b010, M_MK1, 15'h2}, '{3'b010, M_MK1, 15'h3},
			'{3'b100, M_BK1, 15'h0}, '{3'b100, M_DB1, 15'h0}, '{3'b100, M_THR2, 15'h0}, '{3'b001, M_THR2, 15'h7fff},
			'{3'b100, M_MK2, 15'h0}, '{3'b100, M_BK2, 15'h0}, '{3'b100, M_DB2, 15'h0}, '{3'b100, M_THR3, 15'h0},
			'{3'b100, M_DB3, 15'h0}, '{3'b100, M_POL, 15'h7}, '{3'b001, M_POL, 15'h6}, '{3'b100, M_OPER, 15'h0}};
		cyc(12);
		rstn <= 1'b1;
		cyc(1);
		chk(32'(relay_out), 32'h0);
		rdchk(OFS_SETUP, 32'h7);
		for (int i = 0; i < 20; i++) begin
			pr(rows[i].b);
			chk(32'(disp.item), 32'(rows[i].it));
			chk(32'(disp.value), 32'(rows[i].v));
		end
		rdchk(OFS_THR1, 32'h1);
		rdchk(OFS_THR2, 32'hffffffff);
		rdchk(OFS_SETUP, 32'h6);
		bus(1'b1, OFS_THR1, 32'h7);
		rdchk(OFS_THR1, 32'h1);
		rdchk(5'h1c, 32'h0);
		// relay1 low at 1 with 3 s make, relay2 high at -1, relay3 high at 0
		bus(1'b1, OFS_READING, 32'd100);
		cyc(5);
		chk(32'(relay_out), 32'h6);
		chk(32'(alarm_led), 32'h6);
		bus(1'b1, OFS_READING, 32'd0);
		cyc(30);
		chk(32'(relay_out[0]), 32'h0);
		chk(32'(relay_out[2]), 32'h1);
		bus(1'b1, OFS_READING, 32'd5);
		bus(1'b1, OFS_READING, 32'd0);
		cyc(30);
		chk(32'(relay_out[0]), 32'h0);
		n = 0;
		while (relay_out[0] !== 1'b1 && n < 80) begin
			cyc(1);
			n++;
		end
		chk(32'(relay_out[0]), 32'h1);
		bus(1'b1, OFS_READING, 32'hfffffffb);
		cyc(5);
		chk(32'(relay_out), 32'h1);
		rdchk(OFS_READING, 32'hfffffffb);
		lockout_pin <= 1'b1;
		pr(3'b110);
		chk(32'(disp.item), 32'(M_OPER));
		lockout_pin <= 1'b0;
		pr(3'b110);
		pr(3'b010);
		chk(32'(disp.value), 32'h2);
		lbl = disp.show_label;
		cyc(20);
		chk(32'(disp.show_label), 32'(!lbl));
		cyc(400);
		chk(32'(disp.item), 32'(M_OPER));
		rdchk(OFS_THR1, 32'h1);
		// relay2 absent: its items vanish, its alarm only indicates
		relay_fitted_pin <= 3'b101;
		bus(1'b1, OFS_READING, 32'd100);
		cyc(5);
		chk(32'(alarm_ind[1]), 32'h1);
		chk(32'(relay_out[1]), 32'h0);
		rdchk(OFS_STATUS, 32'h2e8);
		pr(3'b110);
		pr(3'b100);
		pr(3'b100);
		pr(3'b001);
		chk(32'(disp.value), 32'h0);
		pr(3'b100);
		pr(3'b100);
		chk(32'(disp.item), 32'(M_THR3));
		// relay2 back, relay3 absent: its deadband item goes, polarity cycles two letters
		relay_fitted_pin <= 3'b011;
		cyc(3);
		pr(3'b100);
		chk(32'(disp.item), 32'(M_POL));
		chk(32'(disp.value), 32'h6);
		pr(3'b010);
		chk(32'(disp.value), 32'h7);
		pr(3'b010);
		chk(32'(disp.value), 32'h4);
		rstn <= 1'b0;
		cyc(3);
		rstn <= 1'b1;
		cyc(1);
		chk(32'(disp.item), 32'(M_OPER));
		rdchk(OFS_THR1, 32'h0);
		rdchk(OFS_SETUP, 32'h7);
		end_of_test();
	end
endmodule
